// ==== dcim_flag_bank.sv ====
// Sticky per-channel event flags, set by hardware and cleared by writing one
`default_nettype none
module dcim_flag_bank
   import dcim_pkg::*;
#(
   parameter int unsigned WIDTH = 32
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Events and clears
   input wire logic [WIDTH-1:0] set_in,
   input wire logic [WIDTH-1:0] clr_in,
   // Flag state
   output logic [WIDTH-1:0] flags_out
);
   logic [WIDTH-1:0] flags_r;
   logic [WIDTH-1:0] flags_nxt;

   // Set beats a clear in the same cycle so no completion is lost
   assign flags_nxt = (flags_r & ~clr_in) | set_in;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flags_r <= WIDTH'(FLAGS_RST);
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign flags_out = flags_r;

   AST_SET_WINS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (set_in != '0) |=> ((flags_r & $past(set_in)) == $past(set_in)))
      else $error("event did not set its flag");

   AST_FALL_ONLY_ON_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      1'b1 |=> (($past(flags_r) & ~flags_r & ~$past(clr_in)) == '0))
      else $error("flag dropped without a clear");
endmodule
`default_nettype wire

// ==== dcim_pkg.sv ====
// Constants, types and decode shared by the DMA channel interrupt status/mask block
`default_nettype none
package dcim_pkg;
   localparam int unsigned BUS_W = 32;
   localparam int unsigned OFF_W = 12;
   // Byte offsets of the register words
   localparam logic [11:0] TFR_FLAGS_OFF = 12'h000;
   localparam logic [11:0] BLK_FLAGS_OFF = 12'h004;
   localparam logic [11:0] TFR_ENABLE_OFF = 12'h008;
   localparam logic [11:0] TFR_PEND_OFF = 12'h00C;
   // Reset and default values, and the AHB word-size and OKAY response codes
   localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
   localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;

   typedef enum logic [1:0] {
      DCIM_PH_IDLE,
      DCIM_PH_WR,
      DCIM_PH_RD_WAIT,
      DCIM_PH_RD_DONE
   } dcim_phase_t;

   typedef enum logic [2:0] {
      DCIM_R_TFR,
      DCIM_R_BLK,
      DCIM_R_EN,
      DCIM_R_PEND,
      DCIM_R_NONE
   } dcim_reg_t;

   function automatic dcim_reg_t dcim_decode(input logic [11:0] off);
      dcim_reg_t r;
      r = DCIM_R_NONE;
      if (off == TFR_FLAGS_OFF) begin
         r = DCIM_R_TFR;
      end else if (off == BLK_FLAGS_OFF) begin
         r = DCIM_R_BLK;
      end else if (off == TFR_ENABLE_OFF) begin
         r = DCIM_R_EN;
      end else if (off == TFR_PEND_OFF) begin
         r = DCIM_R_PEND;
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// ==== dcim_top.sv ====
// AHB-Lite register slave for DMA channel completion flags and interrupt enable
//
// The AHB-Lite slave port is this design's own decision.
`default_nettype none
module dcim_top
   import dcim_pkg::*;
#(
   parameter int unsigned NUM_CH = 32
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   // AHB-Lite slave
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   // Completion events from the DMA channels, one-cycle pulses
   input wire logic [NUM_CH-1:0] TFR_DONE_IN,
   input wire logic [NUM_CH-1:0] BLK_DONE_IN,
   // Interrupt
   output logic IRQ_OUT
);
   dcim_phase_t phase_r;
   dcim_phase_t phase_nxt;
   dcim_reg_t dph_reg_r;
   logic [31:0] hrdata_r;
   logic [NUM_CH-1:0] tfr_enable_r;
   logic [NUM_CH-1:0] tfr_flags;
   logic [NUM_CH-1:0] blk_flags;
   logic [NUM_CH-1:0] tfr_clr;
   logic [NUM_CH-1:0] blk_clr;
   logic [NUM_CH-1:0] tfr_pend;
   logic accept;
   logic wr_commit;

   // Only whole-word transfers are decoded; other sizes complete with no effect
   assign accept = HSEL_IN & HTRANS_IN[1] & HREADY_IN;

   always_comb begin
      phase_nxt = DCIM_PH_IDLE;
      unique case (phase_r)
         DCIM_PH_RD_WAIT: begin
            phase_nxt = DCIM_PH_RD_DONE;
         end
         DCIM_PH_IDLE, DCIM_PH_WR, DCIM_PH_RD_DONE: begin
            if (accept) begin
               phase_nxt = HWRITE_IN ? DCIM_PH_WR : DCIM_PH_RD_WAIT;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         phase_r <= DCIM_PH_IDLE;
         dph_reg_r <= DCIM_R_NONE;
      end else begin
         phase_r <= phase_nxt;
         if (accept) begin
            dph_reg_r <= (HSIZE_IN == HSIZE_WORD) ? dcim_decode(HADDR_IN[OFF_W-1:0])
                                                  : DCIM_R_NONE;
         end
      end
   end

   // Reads take one wait state so that read data comes from a flip-flop
   assign HREADYOUT_OUT = (phase_r != DCIM_PH_RD_WAIT);
   assign HRESP_OUT = HRESP_OKAY;
   assign wr_commit = (phase_r == DCIM_PH_WR);

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         hrdata_r <= UNMAPPED_RD;
      end else if (phase_r == DCIM_PH_RD_WAIT) begin
         unique case (dph_reg_r)
            DCIM_R_TFR: hrdata_r <= 32'(tfr_flags);
            DCIM_R_BLK: hrdata_r <= 32'(blk_flags);
            DCIM_R_EN: hrdata_r <= 32'(tfr_enable_r);
            DCIM_R_PEND: hrdata_r <= 32'(tfr_pend);
            DCIM_R_NONE: hrdata_r <= UNMAPPED_RD;
         endcase
      end
   end

   assign HRDATA_OUT = hrdata_r;

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         tfr_enable_r <= NUM_CH'(ENABLE_RST);
      end else if (wr_commit && dph_reg_r == DCIM_R_EN) begin
         tfr_enable_r <= HWDATA_IN[NUM_CH-1:0];
      end
   end

   // Write-one-to-clear strobes
   assign tfr_clr = (wr_commit && dph_reg_r == DCIM_R_TFR) ? HWDATA_IN[NUM_CH-1:0] : '0;
   assign blk_clr = (wr_commit && dph_reg_r == DCIM_R_BLK) ? HWDATA_IN[NUM_CH-1:0] : '0;

   dcim_flag_bank #(
      .WIDTH(NUM_CH)
   ) u_tfr_flags (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .set_in(TFR_DONE_IN),
      .clr_in(tfr_clr),
      .flags_out(tfr_flags)
   );

   dcim_flag_bank #(
      .WIDTH(NUM_CH)
   ) u_blk_flags (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .set_in(BLK_DONE_IN),
      .clr_in(blk_clr),
      .flags_out(blk_flags)
   );

   // Block-done flags are status only; they never reach the interrupt line
   assign tfr_pend = tfr_flags & tfr_enable_r;
   assign IRQ_OUT = |tfr_pend;

   AST_IRQ_ON_ENABLED_EVENT: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      ((TFR_DONE_IN & tfr_enable_r) != '0 && !wr_commit) |=> IRQ_OUT)
      else $error("enabled completion did not raise interrupt");

   // Checked across a clock edge so that a broken mask or a stray set is caught
   AST_MASKED_STAYS_LOW: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (!IRQ_OUT && (TFR_DONE_IN & tfr_enable_r) == '0 && !wr_commit) |=> !IRQ_OUT)
      else $error("masked completion raised interrupt");

   AST_ENABLE_NEEDS_FLAG: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (tfr_flags == '0 && TFR_DONE_IN == '0) |=> !IRQ_OUT)
      else $error("interrupt high with no flag set");

   AST_IRQ_DROPS: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (tfr_clr != '0 && (tfr_pend & ~tfr_clr) == '0 && TFR_DONE_IN == '0)
      |=> !IRQ_OUT)
      else $error("interrupt stayed high after enabled flags cleared");

   AST_ENABLE_WRITE: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (accept && HWRITE_IN && HSIZE_IN == HSIZE_WORD
       && HADDR_IN[OFF_W-1:0] == TFR_ENABLE_OFF)
      ##1 1'b1 |=> (tfr_enable_r == $past(HWDATA_IN[NUM_CH-1:0])))
      else $error("enable register did not take written value");

   AST_READ_ONE_WAIT: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (accept && !HWRITE_IN) |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
      else $error("read did not take exactly one wait state");

   AST_BLK_READBACK: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (phase_r == DCIM_PH_RD_WAIT && dph_reg_r == DCIM_R_BLK)
      |=> (HRDATA_OUT == 32'($past(blk_flags))))
      else $error("block flags read back wrong");

   // Bus protocol checks
   AST_WRITE_NO_WAIT: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (accept && HWRITE_IN) |=> HREADYOUT_OUT)
      else $error("write inserted a wait state");

   AST_PHASE_AFTER_WAIT: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (phase_r == DCIM_PH_RD_WAIT) |=> (phase_r == DCIM_PH_RD_DONE))
      else $error("read wait state not followed by its data cycle");

   AST_NONWORD_IGNORED: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (accept && HSIZE_IN != HSIZE_WORD) |=> (dph_reg_r == DCIM_R_NONE))
      else $error("non-word transfer was decoded");

   // Read data only moves when a read loads it, so software sees a steady word
   AST_RDATA_HOLDS: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (phase_r != DCIM_PH_RD_WAIT) |=> $stable(HRDATA_OUT))
      else $error("read data changed outside a read");

   // Register content checks
   AST_ENABLE_HOLDS: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      !(wr_commit && dph_reg_r == DCIM_R_EN) |=> $stable(tfr_enable_r))
      else $error("enable register changed without a write");

   AST_ENABLE_READBACK: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (phase_r == DCIM_PH_RD_WAIT && dph_reg_r == DCIM_R_EN)
      |=> (HRDATA_OUT == 32'($past(tfr_enable_r))))
      else $error("enable register read back wrong");

   AST_PEND_READBACK: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (phase_r == DCIM_PH_RD_WAIT && dph_reg_r == DCIM_R_PEND)
      |=> (HRDATA_OUT == 32'($past(tfr_flags) & $past(tfr_enable_r))))
      else $error("pending word read back wrong");

   AST_UNMAPPED_ZERO: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (phase_r == DCIM_PH_RD_WAIT && dph_reg_r == DCIM_R_NONE)
      |=> (HRDATA_OUT == UNMAPPED_RD))
      else $error("unmapped read returned data");

   // A clear only wins where no event arrives in the same cycle
   AST_BLK_CLEAR: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (blk_clr != '0 && BLK_DONE_IN == '0)
      |=> ((blk_flags & $past(blk_clr)) == '0))
      else $error("block flag survived its clear");

   AST_TFR_CLEAR: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (tfr_clr != '0 && TFR_DONE_IN == '0)
      |=> ((tfr_flags & $past(tfr_clr)) == '0))
      else $error("transfer flag survived its clear");

   // Coverage of the main scenarios

   COV_IRQ_RISE: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN) $rose(IRQ_OUT));
   COV_IRQ_CLEARED: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      $fell(IRQ_OUT) && $past(wr_commit));
   COV_BLK_W1C: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      blk_clr != '0 && blk_flags != '0);
   COV_SET_WINS: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (blk_clr & BLK_DONE_IN) != '0);
   COV_MASKED_EVENT: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      (TFR_DONE_IN & ~tfr_enable_r) != '0);
endmodule
`default_nettype wire

// ==== test_dcim_top.sv ====
// Self-checking bench for the DMA channel completion flag and enable block
`default_nettype none
module test_dcim_top
   import dcim_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] tfr = 32'h0;
   logic [31:0] blk = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic irq;
   logic [31:0] rd, t, e, b, c;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;

   always #5 clk_in = ~clk_in;

   dcim_top #(.NUM_CH(32)) dut (.CLK_IN(clk_in), .RST_B_IN(rst_b_in), .HSEL_IN(hsel),
      .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
      .HWDATA_IN(hwdata), .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata),
      .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp), .TFR_DONE_IN(tfr),
      .BLK_DONE_IN(blk), .IRQ_OUT(irq));

   function automatic logic [31:0] exp_irq(input logic [31:0] fl, input logic [31:0] en);
      return {31'h0, |(fl & en)};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One single transfer; waits on the slave's own ready, never on a fixed count
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_in);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h00000, a};
      do @(posedge clk_in); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_in); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   task automatic pulse(input logic [31:0] tp, input logic [31:0] bp);
      @(posedge clk_in);
      tfr <= tp;
      blk <= bp;
      @(posedge clk_in);
      tfr <= 32'h0;
      blk <= 32'h0;
      @(posedge clk_in);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         wrap_up();
      end
   end

   initial begin
      void'($urandom(32'h7A61));
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rdchk(12'(i * 4), 32'h0);
      end
      chk({31'h0, irq}, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         e = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         bus(1'b1, TFR_ENABLE_OFF, e, rd);
         rdchk(TFR_ENABLE_OFF, e);
      end
      // Unmapped write must not alias onto the enable word
      bus(1'b1, 12'h010, ~e, rd);
      rdchk(12'h010, 32'h0);
      rdchk(TFR_ENABLE_OFF, e);
      // A byte-sized write is decoded as unmapped and leaves the enable word alone
      hsize <= 3'h0;
      bus(1'b1, TFR_ENABLE_OFF, ~e, rd);
      hsize <= HSIZE_WORD;
      rdchk(TFR_ENABLE_OFF, e);
      chk({31'h0, hresp}, 32'h0);
      $display("test enable done");
      b = $urandom;
      pulse(32'h0, b);
      rdchk(BLK_FLAGS_OFF, b);
      chk({31'h0, irq}, 32'h0);
      c = $urandom;
      bus(1'b1, BLK_FLAGS_OFF, c, rd);
      rdchk(BLK_FLAGS_OFF, b & ~c);
      pulse(32'h0, 32'h0000_1001);
      rdchk(BLK_FLAGS_OFF, (b & ~c) | 32'h0000_1001);
      // Event lands in the very cycle its flag is cleared: the set must survive
      fork
         bus(1'b1, BLK_FLAGS_OFF, 32'h0000_0001, rd);
         begin
            repeat (2) @(posedge clk_in);
            blk <= 32'h0000_0001;
            @(posedge clk_in);
            blk <= 32'h0;
         end
      join
      rdchk(BLK_FLAGS_OFF, (b & ~c) | 32'h0000_1001);
      $display("test block flags done");
      for (int i = 0; i < 8; i++) begin
         e = (i == 0) ? 32'h0 : (i == 1) ? 32'h8000_0000 : $urandom;
         t = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h8000_0000 : $urandom;
         bus(1'b1, TFR_ENABLE_OFF, e, rd);
         pulse(t, 32'h0);
         chk({31'h0, irq}, exp_irq(t, e));
         rdchk(TFR_FLAGS_OFF, t);
         rdchk(TFR_PEND_OFF, t & e);
         bus(1'b1, TFR_FLAGS_OFF, 32'hFFFF_FFFF, rd);
         @(posedge clk_in);
         chk({31'h0, irq}, 32'h0);
      end
      $display("test transfer interrupt done");
      wrap_up();
   end
endmodule
`default_nettype wire
